// *** verilog/txtoh_marker.sv ***
`timescale 1ns/100ps
// Overview of operation
// - telecom bus enabled: pin marks overhead; else send gate, HDLC mode only
// - in bus mode the pin tells whether the bus byte is overhead
// - marker sampled at falling edge of the telecom bus clock
// - send gate high: capture payload byte at each payload clock rising edge
// - captured bytes go into an outgoing frame carried in DS3/E3 payload
// - send gate low: ignore payload inputs, emit continuous 0x7e flags
module txtoh_marker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // mode straps
  input wire logic tb_enable_in,
  input wire logic hdlc_mode_in,
  // shared pin
  input wire logic tx_overhead_marker_ch1_in,
  // telecom bus
  input wire logic tx_telecom_bus_clock_ch1_in,
  input wire logic [7:0] tx_telecom_byte_bus_ch1_in,
  // hdlc payload port
  input wire logic tx_frame_payload_clock_ch1_in,
  input wire logic [7:0] tx_frame_payload_in_ch1_in,
  // telecom bus result
  output txtoh_pkg::txtoh_tb_out_t tb_out,
  // octet toward the frame generator payload
  output logic [7:0] frame_octet_out,
  output logic frame_octet_valid_out,
  output logic frame_is_data_out
);
  // ==========================================================
  // state
  typedef struct packed {
    txtoh_pkg::txtoh_pins_t prev;
    logic [7:0] tb_d1;
    logic [7:0] tb_d2;
    logic [7:0] fr_d1;
    logic [7:0] fr_d2;
    txtoh_pkg::txtoh_tb_out_t tb;
    logic [7:0] octet;
    logic octet_v;
    logic is_data;
  } txtoh_st_t;

  txtoh_st_t st_r;
  txtoh_st_t st_nxt;
  txtoh_pkg::txtoh_pins_t pins_s;
  txtoh_pkg::txtoh_role_t role;

  // ==========================================================
  // pin synchronisers; data buses settle well before the sampling edge
  // all three levels cross in one vector so they share one delay
  txtoh_sync #(
    .W(3)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in({tx_overhead_marker_ch1_in, tx_telecom_bus_clock_ch1_in, tx_frame_payload_clock_ch1_in}),
    .sync_out(pins_s)
  );

  // role select; idle when neither mode applies
  function automatic txtoh_pkg::txtoh_role_t role_of(input logic tb_en, input logic hd);
    if (tb_en) begin
      role_of = txtoh_pkg::TXTOH_ROLE_MARK;
    end else if (hd) begin
      role_of = txtoh_pkg::TXTOH_ROLE_SEND;
    end else begin
      role_of = txtoh_pkg::TXTOH_ROLE_IDLE;
    end
  endfunction

  assign role = role_of(tb_enable_in, hdlc_mode_in);

  // ==========================================================
  // edge finders on synced levels; one pair serves both link clocks
  function automatic logic edge_fell(input logic prev_lvl, input logic cur_lvl);
    edge_fell = prev_lvl && !cur_lvl;
  endfunction

  // reset level of zero matches both clocks' idle level, so no false rise
  function automatic logic edge_rose(input logic prev_lvl, input logic cur_lvl);
    edge_rose = !prev_lvl && cur_lvl;
  endfunction

  // ==========================================================
  // next state
  // timing per byte, in ref clock cycles from the link clock edge:
  //   +1 first sync stage, +2 second stage, edge seen against prev
  //   +3 result register loaded, strobe stands for that one cycle
  // byte buses take two plain register stages, not a synchroniser,
  // so the source must hold them steady three cycles either side
  // of the sampling edge; a link clock under 40 ns period can lose edges
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = pins_s;
    st_nxt.tb_d1 = tx_telecom_byte_bus_ch1_in;
    st_nxt.tb_d2 = st_r.tb_d1; // aligned with synced clock
    st_nxt.fr_d1 = tx_frame_payload_in_ch1_in;
    st_nxt.fr_d2 = st_r.fr_d1;
    // result strobes default low; they stand one cycle only
    st_nxt.tb.valid = 1'b0;
    st_nxt.octet_v = 1'b0;
    // at most one role owns the shared pin at any time; none in idle
    case (role)
      txtoh_pkg::TXTOH_ROLE_MARK: begin
        // falling edge of bus clock samples marker and byte
        if (edge_fell(st_r.prev.tb_clk, pins_s.tb_clk)) begin
          st_nxt.tb.valid = 1'b1;
          st_nxt.tb.data = st_r.tb_d2;
          st_nxt.tb.is_overhead = ~pins_s.pin;
        end
      end
      txtoh_pkg::TXTOH_ROLE_SEND: begin
        // rising payload clock: byte if gate high, flag otherwise
        if (edge_rose(st_r.prev.fr_clk, pins_s.fr_clk)) begin
          st_nxt.octet_v = 1'b1;
          if (pins_s.pin) begin
            st_nxt.octet = st_r.fr_d2;
            st_nxt.is_data = 1'b1;
          end else begin
            st_nxt.octet = txtoh_pkg::TXTOH_FLAG_OCTET;
            st_nxt.is_data = 1'b0;
          end
        end
      end
      default: begin
        // pin ignored; no octets or flags emitted, no capture
        st_nxt.is_data = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      // octet rests at the flag so a reader sees idle fill
      st_r <= '0;
      st_r.octet <= txtoh_pkg::TXTOH_FLAG_OCTET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign tb_out = st_r.tb;
  assign frame_octet_out = st_r.octet;
  assign frame_octet_valid_out = st_r.octet_v;
  assign frame_is_data_out = st_r.is_data;

  // ==========================================================
  // checks: roles of the shared pin
  a_bus_no_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tb_enable_in |=> !frame_octet_valid_out)
    else $error("capture while telecom bus enabled");
  a_send_not_bus: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out |-> $past(!tb_enable_in))
    else $error("octet produced in bus role");
  a_role_exclusive: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !(tb_out.valid && frame_octet_valid_out))
    else $error("both roles active at once");
  a_mode_only: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out |-> $past(hdlc_mode_in))
    else $error("send role outside hdlc mode");
  a_idle_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !tb_enable_in && !hdlc_mode_in |=> !tb_out.valid && !frame_octet_valid_out)
    else $error("activity in idle role");
  a_idle_no_data: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !tb_enable_in && !hdlc_mode_in |=> !frame_is_data_out)
    else $error("data flag set in idle role");

  // checks: overhead marker on the telecom bus
  a_marker_polarity: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tb_out.valid |-> tb_out.is_overhead == !$past(pins_s.pin))
    else $error("overhead marker polarity wrong");
  a_fall_sample: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tb_out.valid |-> $past(tb_enable_in) && $past(pins_s.tb_clk, 2) && !$past(pins_s.tb_clk))
    else $error("marker sampled off falling edge");
  a_bus_data_pipe: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tb_out.valid |-> tb_out.data == $past(tx_telecom_byte_bus_ch1_in, 3))
    else $error("bus byte not the one at the edge");
  a_bus_data_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !tb_out.valid |-> $stable(tb_out.data))
    else $error("bus byte changed without strobe");
  a_bus_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tb_out.valid |=> !tb_out.valid)
    else $error("bus strobe longer than one cycle");

  // checks: send gate on the payload port
  a_gate_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out && frame_is_data_out |-> $past(pins_s.pin) && $past(!tb_enable_in))
    else $error("byte captured with gate low");
  a_rise_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out |-> !$past(pins_s.fr_clk, 2) && $past(pins_s.fr_clk))
    else $error("octet off rising edge");
  a_octet_data_pipe: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out && frame_is_data_out |-> frame_octet_out == $past(tx_frame_payload_in_ch1_in, 3))
    else $error("payload byte not the one at the edge");
  a_octet_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out |=> !frame_octet_valid_out)
    else $error("octet strobe longer than one cycle");
  a_flag_when_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    frame_octet_valid_out && !frame_is_data_out |-> frame_octet_out == txtoh_pkg::TXTOH_FLAG_OCTET)
    else $error("idle octet not a flag");
  a_octet_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !frame_octet_valid_out |-> $stable(frame_octet_out))
    else $error("octet changed without strobe");

  // main scenarios: both marker levels, data, flags, idle role
  c_overhead: cover property (@(posedge ref_clk_in) tb_out.valid && tb_out.is_overhead);
  c_payload_byte: cover property (@(posedge ref_clk_in) tb_out.valid && !tb_out.is_overhead);
  c_data: cover property (@(posedge ref_clk_in) frame_octet_valid_out && frame_is_data_out);
  c_flag: cover property (@(posedge ref_clk_in) frame_octet_valid_out && !frame_is_data_out);
  c_idle: cover property (@(posedge ref_clk_in) !rst_in && !tb_enable_in && !hdlc_mode_in);
endmodule

// *** verilog/txtoh_pkg.sv ***
package txtoh_pkg;
  // ==========================================================
  // constants
  localparam logic [7:0] TXTOH_FLAG_OCTET = 8'h7e;
  localparam int TXTOH_BYTE_W = 8;
  localparam logic [1:0] TXTOH_SYNC_RST = 2'h0;

  // ==========================================================
  // pin role of the shared input
  typedef enum logic [1:0] {
    TXTOH_ROLE_IDLE = 2'b00,
    TXTOH_ROLE_SEND = 2'b01,
    TXTOH_ROLE_MARK = 2'b11
  } txtoh_role_t;

  // ==========================================================
  // pin samples carried as one group
  typedef struct packed {
    logic pin;
    logic tb_clk;
    logic fr_clk;
  } txtoh_pins_t;

  // telecom bus side output group
  typedef struct packed {
    logic [7:0] data;
    logic is_overhead;
    logic valid;
  } txtoh_tb_out_t;
endpackage

// *** verilog/txtoh_sync.sv ***
`timescale 1ns/100ps
// ==========================================================
// two-flop synchroniser for a vector of pin levels
module txtoh_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // async level in, synced level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } txtoh_sync_st_t;

  txtoh_sync_st_t st_r;
  txtoh_sync_st_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = async_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.sync;
endmodule

// *** bench/txtoh_source.sv ***
`timescale 1ns/100ps
// ==========================================================
// upstream source: one byte per 130 ns call, link clock high for 40 ns
module txtoh_source (
  // clock and the mode the board is strapped to
  input wire logic ref_clk_in,
  input wire logic bus_mode_in,
  // link side
  output logic pin_out = 1'b0,
  output logic tb_clk_out = 1'b0,
  output logic [7:0] tb_byte_out = 8'h00,
  output logic fr_clk_out = 1'b0,
  output logic [7:0] fr_byte_out = 8'h00
);
  // clocks stand low between bytes; bus_sel picks the lane
  task automatic send(input logic bus_sel, input logic [7:0] value, input logic level);
    @(posedge ref_clk_in);
    tb_byte_out <= bus_sel ? value : tb_byte_out;
    fr_byte_out <= bus_sel ? fr_byte_out : value;
    pin_out <= level;
    repeat (4) @(posedge ref_clk_in);
    tb_clk_out <= bus_sel;
    fr_clk_out <= ~bus_sel;
    repeat (4) @(posedge ref_clk_in);
    tb_clk_out <= 1'b0;
    fr_clk_out <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    // released lines show the inverse so a late sample cannot match
    tb_byte_out <= ~tb_byte_out;
    fr_byte_out <= ~fr_byte_out;
    // after a bus-lane byte the pin rests high in bus role, else low; a payload-lane byte leaves it as set
    if (bus_sel) pin_out <= bus_mode_in;
  endtask
endmodule

// *** bench/tx_toh_marker_hdlc_send_input_test.sv ***
`timescale 1ns/100ps
// ==========================================================
// bench top
module tx_toh_marker_hdlc_send_input_test;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic tb_en = 1'b0;
  logic hdlc_en = 1'b0;
  logic pin, tb_clk, fr_clk, octet_valid, is_data, fr_last_data;
  logic [7:0] tb_byte, fr_byte, octet, fr_last;
  txtoh_pkg::txtoh_tb_out_t tb_res, bus_last;
  int bad_count = 0;
  int comparisons = 0;
  int bus_hits = 0;
  int fr_hits = 0;

  // 100 MHz
  always #5 ref_clk_in = ~ref_clk_in;

  txtoh_source i_txtoh_source (.ref_clk_in(ref_clk_in), .bus_mode_in(tb_en), .pin_out(pin), .tb_clk_out(tb_clk),
    .tb_byte_out(tb_byte), .fr_clk_out(fr_clk), .fr_byte_out(fr_byte));
  txtoh_marker i_txtoh_marker (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tb_enable_in(tb_en),
    .hdlc_mode_in(hdlc_en), .tx_overhead_marker_ch1_in(pin), .tx_telecom_bus_clock_ch1_in(tb_clk),
    .tx_telecom_byte_bus_ch1_in(tb_byte), .tx_frame_payload_clock_ch1_in(fr_clk),
    .tx_frame_payload_in_ch1_in(fr_byte), .tb_out(tb_res), .frame_octet_out(octet),
    .frame_octet_valid_out(octet_valid), .frame_is_data_out(is_data));

  // valid stands one cycle, so count it at every edge
  always @(posedge ref_clk_in) begin
    if (tb_res.valid === 1'b1) begin
      bus_hits++;
      bus_last = tb_res;
    end
    if (octet_valid === 1'b1) begin
      fr_hits++;
      fr_last = octet;
      fr_last_data = is_data;
    end
  end

  // ==========================================================
  // helpers
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_bus(input int hits, input logic [7:0] data, input logic ovh);
    comparisons++;
    if (bus_hits != hits || (hits > 0 && (bus_last.data !== data || bus_last.is_overhead !== ovh))) begin
      bad_count++;
      $display("unexpected at %0t: telecom bus result", $time);
    end
  endtask

  task automatic check_frame(input int hits, input logic [7:0] data, input logic is_d);
    comparisons++;
    if (fr_hits != hits || (hits > 0 && (fr_last !== data || fr_last_data !== is_d))) begin
      bad_count++;
      $display("unexpected at %0t: frame octet result", $time);
    end
  endtask

  // settle time covers two sync flops plus the output register
  task automatic run_one(input logic bus_sel, input logic [7:0] value, input logic level);
    bus_hits = 0;
    fr_hits = 0;
    i_txtoh_source.send(bus_sel, value, level);
    repeat (6) @(posedge ref_clk_in);
  endtask

  task automatic set_mode(input logic bus_on, input logic hdlc_on);
    @(posedge ref_clk_in);
    tb_en <= bus_on;
    hdlc_en <= hdlc_on;
    repeat (4) @(posedge ref_clk_in);
  endtask

  // ==========================================================
  // scenarios
  task automatic bus_role_scenario();
    set_mode(1'b1, 1'b1);
    run_one(1'b1, 8'ha5, 1'b0);
    check_bus(1, 8'ha5, 1'b1);
    run_one(1'b1, 8'h3c, 1'b1);
    check_bus(1, 8'h3c, 1'b0);
    check_frame(0, 8'h00, 1'b0);
    run_one(1'b0, 8'h5a, 1'b1);
    check_frame(0, 8'h00, 1'b0);
  endtask

  task automatic gate_role_scenario();
    set_mode(1'b0, 1'b1);
    run_one(1'b0, 8'h5a, 1'b1);
    check_frame(1, 8'h5a, 1'b1);
    run_one(1'b0, 8'h81, 1'b1);
    check_frame(1, 8'h81, 1'b1);
    run_one(1'b0, 8'h24, 1'b0);
    check_frame(1, txtoh_pkg::TXTOH_FLAG_OCTET, 1'b0);
    run_one(1'b1, 8'hc3, 1'b0);
    check_bus(0, 8'h00, 1'b0);
  endtask

  // neither role: pin tied low, nothing may come out
  task automatic idle_role_scenario();
    set_mode(1'b0, 1'b0);
    run_one(1'b0, 8'h66, 1'b0);
    check_frame(0, 8'h00, 1'b0);
    run_one(1'b1, 8'h99, 1'b0);
    check_bus(0, 8'h00, 1'b0);
  endtask

  // main sequence, reset value of the octet checked first
  initial begin
    repeat (16) @(posedge ref_clk_in);
    fr_hits = 1;
    fr_last = octet;
    fr_last_data = is_data;
    check_frame(1, txtoh_pkg::TXTOH_FLAG_OCTET, 1'b0);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    bus_role_scenario();
    gate_role_scenario();
    idle_role_scenario();
    complete_run();
  end

  // watchdog: the run needs about 2 us, so 20 us means a hang
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule
